/* common/meter_cal_pkg.sv */
// Constants, register map and field layout for the calibration and no-load block.
package meter_cal_pkg;

  // ---------------------------------------------------------------------------
  // Clock and rates
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ            = 250_000_000;
  localparam int ACCUM_HZ_FAST     = 12800;
  localparam int ACCUM_HZ_SLOW     = 2979;
  localparam int BPF_SAMPLE_HZ_LOW = 800;
  localparam int BPF_SAMPLE_HZ_NOM = 3200;
  // Shortest period, so rounding down by integer division.
  localparam int ACCUM_CYC_FAST    = CLK_HZ / ACCUM_HZ_FAST;
  localparam int ACCUM_CYC_SLOW    = CLK_HZ / ACCUM_HZ_SLOW;
  localparam int BPF_CYC_LOW       = CLK_HZ / BPF_SAMPLE_HZ_LOW;
  localparam int BPF_CYC_NOM       = CLK_HZ / BPF_SAMPLE_HZ_NOM;
  localparam int DIV_W             = 20;

  // ---------------------------------------------------------------------------
  // Metering clock rate codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RATE_3M2768 = 2'h0;
  localparam logic [1:0] RATE_1M6384 = 2'h1;
  localparam logic [1:0] RATE_819K2  = 2'h2;
  localparam logic [1:0] RATE_32K768 = 2'h3;

  // ---------------------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------------------
  localparam int ACC_W          = 42;
  localparam int PAD_W          = 10;
  localparam int IDX_W          = 14;
  localparam int CTRL_ACC_EN    = 0;
  localparam int CTRL_CF_EN     = 1;
  localparam int CTRL_NOLOAD_EN = 2;
  localparam int CTRL_CONST_SEL = 3;
  localparam int CTRL_RATE_LSB  = 4;
  localparam int CREEP_BIT_P1   = 7;
  localparam int CREEP_BIT_P2   = 6;
  localparam int IRQ_W          = 4;
  localparam int IRQ_OVF_LSB    = 0;
  localparam int IRQ_CREEP_LSB  = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CURRENT_DETECT_THRESHOLD = 14'h1002;
  localparam logic [IDX_W-1:0] IDX_GAIN_CAL_POWER_PATH1     = 14'h10E8;
  localparam logic [IDX_W-1:0] IDX_GAIN_CAL_POWER_PATH2     = 14'h10E9;
  localparam logic [IDX_W-1:0] IDX_GAIN_CAL_VOLTAGE_RMS     = 14'h10EA;
  localparam logic [IDX_W-1:0] IDX_GAIN_CAL_CURRENT_ONE_RMS = 14'h10EB;
  localparam logic [IDX_W-1:0] IDX_GAIN_CAL_CURRENT_TWO_RMS = 14'h10EC;
  localparam logic [IDX_W-1:0] IDX_OFFSET_CAL_POWER_PATH1   = 14'h10ED;
  localparam logic [IDX_W-1:0] IDX_OFFSET_CAL_POWER_PATH2   = 14'h10EE;
  localparam logic [IDX_W-1:0] IDX_RMS_BANDPASS_COEFFICIENT = 14'h10EF;
  localparam logic [IDX_W-1:0] IDX_PULSE_THRESHOLD_PATH1    = 14'h10F4;
  localparam logic [IDX_W-1:0] IDX_NOLOAD_THRESHOLD_PATH1   = 14'h10F5;
  localparam logic [IDX_W-1:0] IDX_PULSE_THRESHOLD_PATH2    = 14'h10FA;
  localparam logic [IDX_W-1:0] IDX_NOLOAD_THRESHOLD_PATH2   = 14'h10FB;
  localparam logic [IDX_W-1:0] IDX_CONSTANT_POWER_VALUE     = 14'h10FC;
  localparam logic [IDX_W-1:0] IDX_ENERGY_ACC_PATH1         = 14'h10F0;
  localparam logic [IDX_W-1:0] IDX_ENERGY_ACC_PATH2         = 14'h10F6;
  localparam logic [IDX_W-1:0] IDX_METER_CONTROL            = 14'h1100;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS               = 14'h1101;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK                 = 14'h1102;
  localparam logic [IDX_W-1:0] IDX_CREEP_STATUS             = 14'h287F;

  // ---------------------------------------------------------------------------
  // Calibration word table; slot order fixes the output wiring
  // ---------------------------------------------------------------------------
  localparam int NUM_CAL          = 14;
  localparam int SLOT_IDET        = 0;
  localparam int SLOT_GAIN_P1     = 1;
  localparam int SLOT_GAIN_P2     = 2;
  localparam int SLOT_GAIN_U      = 3;
  localparam int SLOT_GAIN_I1     = 4;
  localparam int SLOT_GAIN_I2     = 5;
  localparam int SLOT_OFS_P1      = 6;
  localparam int SLOT_OFS_P2      = 7;
  localparam int SLOT_BPF         = 8;
  localparam int SLOT_PULSE_P1    = 9;
  localparam int SLOT_NOLOAD_P1   = 10;
  localparam int SLOT_PULSE_P2    = 11;
  localparam int SLOT_NOLOAD_P2   = 12;
  localparam int SLOT_CONST       = 13;
  localparam logic [31:0] BPF_COEF_RESET = 32'h8893_74BC;
  localparam logic [IDX_W-1:0] CAL_INDEX [NUM_CAL] = '{
    IDX_CURRENT_DETECT_THRESHOLD, IDX_GAIN_CAL_POWER_PATH1,
    IDX_GAIN_CAL_POWER_PATH2, IDX_GAIN_CAL_VOLTAGE_RMS,
    IDX_GAIN_CAL_CURRENT_ONE_RMS, IDX_GAIN_CAL_CURRENT_TWO_RMS,
    IDX_OFFSET_CAL_POWER_PATH1, IDX_OFFSET_CAL_POWER_PATH2,
    IDX_RMS_BANDPASS_COEFFICIENT, IDX_PULSE_THRESHOLD_PATH1,
    IDX_NOLOAD_THRESHOLD_PATH1, IDX_PULSE_THRESHOLD_PATH2,
    IDX_NOLOAD_THRESHOLD_PATH2, IDX_CONSTANT_POWER_VALUE};
  localparam logic [31:0] CAL_RESET [NUM_CAL] = '{
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    BPF_COEF_RESET, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

endpackage

/* rtl/meter_calibration_anticreep.sv */
// Calibration registers, energy/no-load race and pulse logic of the meter.
//
// Behaviour
// - All calibration words return to defaults on any of the three resets.
// - Five signed 32-bit gain words, zero at reset, range up to +49.9%.
// - Two signed 32-bit power offset words, zero at reset, +-50% range.
// - Band-pass coefficient word resets to 0x889374BC.
// - At 819.2kHz the band-pass filter samples at 800Hz, centre 12.5Hz.
// - Pulse thresholds gain ten low zero bits to meet 42-bit sums.
// - Anti-creep count adds one at 12800Hz, or 2979Hz at 32768Hz.
// - Energy overflow first clears the anti-creep count; path meters.
// - Anti-creep first clears energy, path creeps; status bits 7 and 6.
// - Signed 32-bit constant may replace measured power on path one.
// - Each path has an unsigned 32-bit pulse threshold, zero at reset.
// - Each path has an unsigned 32-bit no-load threshold, zero at reset.
// - Current detect threshold: signed, bits 31 and 30 both sign, zero.
// - Accumulators show only their upper 32 bits; writes zero low ten.
// - With pulse output enabled, one pulse per two energy overflows.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps

module meter_calibration_anticreep
  import meter_cal_pkg::*;
#(
  parameter int ACCUM_CYCLES_FAST = ACCUM_CYC_FAST,
  parameter int ACCUM_CYCLES_SLOW = ACCUM_CYC_SLOW,
  parameter int BPF_CYCLES_LOW    = BPF_CYC_LOW,
  parameter int BPF_CYCLES_NOM    = BPF_CYC_NOM
) (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        resetBrownOut,
  input  wire logic        resetWatchdog,
  // Wishbone classic slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [15:0] wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatWr,
  output logic      [31:0] wbDatRd,
  output logic             wbAck,
  // Measured power of both paths
  input  wire logic [31:0] powerPathOne,
  input  wire logic [31:0] powerPathTwo,
  // Calibration words towards the measurement datapath
  output logic      [31:0] currentDetectThreshold,
  output logic      [31:0] gainCalPowerPath1,
  output logic      [31:0] gainCalPowerPath2,
  output logic      [31:0] gainCalVoltageRms,
  output logic      [31:0] gainCalCurrentOneRms,
  output logic      [31:0] gainCalCurrentTwoRms,
  output logic      [31:0] offsetCalPowerPath1,
  output logic      [31:0] offsetCalPowerPath2,
  output logic      [31:0] rmsBandpassCoefficient,
  output logic             bpfSampleEn,
  // Pulse, creep and interrupt outputs
  output logic             calPulseOutOne,
  output logic             calPulseOutTwo,
  output logic             creepOne,
  output logic             creepTwo,
  output logic             irq
);

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  logic [IDX_W-1:0] regIdx;
  logic             ack_reg, ack_next;
  logic [31:0]      rdData_reg, rdData_next;
  logic             wrEn;
  logic             softClear;

  assign regIdx    = wbAdr[15:2];
  // A write commits on the edge where the master sees ack, so data is stable.
  assign wrEn      = wbCyc & wbStb & wbWe & ack_reg;
  assign softClear = resetBrownOut | resetWatchdog;

  function automatic logic [31:0] mergeSel(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------------------
  // Calibration word file
  // ---------------------------------------------------------------------------
  logic [31:0] cal_reg  [NUM_CAL];
  logic [31:0] cal_next [NUM_CAL];

  always_comb begin
    for (int i = 0; i < NUM_CAL; i++) begin
      cal_next[i] = cal_reg[i];
      if (softClear) begin
        cal_next[i] = CAL_RESET[i];
      end else if (wrEn && regIdx == CAL_INDEX[i]) begin
        cal_next[i] = mergeSel(cal_reg[i], wbDatWr, wbSel);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_CAL; i++) begin
        cal_reg[i] <= CAL_RESET[i];
      end
    end else begin
      for (int i = 0; i < NUM_CAL; i++) begin
        cal_reg[i] <= cal_next[i];
      end
    end
  end

  // The current threshold is stored whole; bits 31 and 30 both carry sign.
  assign currentDetectThreshold = cal_reg[SLOT_IDET];
  assign gainCalPowerPath1      = cal_reg[SLOT_GAIN_P1];
  assign gainCalPowerPath2      = cal_reg[SLOT_GAIN_P2];
  assign gainCalVoltageRms      = cal_reg[SLOT_GAIN_U];
  assign gainCalCurrentOneRms   = cal_reg[SLOT_GAIN_I1];
  assign gainCalCurrentTwoRms   = cal_reg[SLOT_GAIN_I2];
  assign offsetCalPowerPath1    = cal_reg[SLOT_OFS_P1];
  assign offsetCalPowerPath2    = cal_reg[SLOT_OFS_P2];
  assign rmsBandpassCoefficient = cal_reg[SLOT_BPF];

  // ---------------------------------------------------------------------------
  // Control, interrupt status and mask
  // ---------------------------------------------------------------------------
  logic [31:0]      ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0] irqStat_reg, irqStat_next;
  logic [IRQ_W-1:0] irqMask_reg, irqMask_next;
  logic [IRQ_W-1:0] irqEvents;
  logic             accEn, cfEn, noloadEn, constSel;
  logic [1:0]       rate;

  assign accEn    = ctrl_reg[CTRL_ACC_EN];
  assign cfEn     = ctrl_reg[CTRL_CF_EN];
  assign noloadEn = ctrl_reg[CTRL_NOLOAD_EN];
  assign constSel = ctrl_reg[CTRL_CONST_SEL];
  assign rate     = ctrl_reg[CTRL_RATE_LSB +: 2];

  always_comb begin
    ctrl_next    = ctrl_reg;
    irqMask_next = irqMask_reg;
    // An event in the cycle of its clear wins over the clear.
    irqStat_next = irqStat_reg | irqEvents;
    if (softClear) begin
      ctrl_next    = CTRL_RESET;
      irqMask_next = '0;
      irqStat_next = '0;
    end else if (wrEn) begin
      if (regIdx == IDX_METER_CONTROL) begin
        ctrl_next = mergeSel(ctrl_reg, wbDatWr, wbSel);
      end
      if (regIdx == IDX_IRQ_MASK && wbSel[0]) begin
        irqMask_next = wbDatWr[IRQ_W-1:0];
      end
      if (regIdx == IDX_IRQ_STATUS && wbSel[0]) begin
        irqStat_next = (irqStat_reg & ~wbDatWr[IRQ_W-1:0]) | irqEvents;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg    <= CTRL_RESET;
      irqMask_reg <= '0;
      irqStat_reg <= '0;
    end else begin
      ctrl_reg    <= ctrl_next;
      irqMask_reg <= irqMask_next;
      irqStat_reg <= irqStat_next;
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // ---------------------------------------------------------------------------
  // Rate dividers
  // ---------------------------------------------------------------------------
  // The metering rate is told by software; this block does not measure it.
  logic [DIV_W-1:0] accDiv_reg, accDiv_next, accLimit;
  logic [DIV_W-1:0] bpfDiv_reg, bpfDiv_next, bpfLimit;
  logic             accTick;
  logic             bpfTick_reg, bpfTick_next;

  always_comb begin
    accLimit = (rate == RATE_32K768) ? DIV_W'(ACCUM_CYCLES_SLOW - 1)
                                     : DIV_W'(ACCUM_CYCLES_FAST - 1);
    bpfLimit = (rate == RATE_819K2) ? DIV_W'(BPF_CYCLES_LOW - 1)
                                    : DIV_W'(BPF_CYCLES_NOM - 1);
    accTick      = (accDiv_reg >= accLimit);
    accDiv_next  = accTick ? '0 : accDiv_reg + DIV_W'(1);
    bpfTick_next = (bpfDiv_reg >= bpfLimit);
    bpfDiv_next  = bpfTick_next ? '0 : bpfDiv_reg + DIV_W'(1);
    if (softClear) begin
      accDiv_next  = '0;
      bpfDiv_next  = '0;
      bpfTick_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      accDiv_reg  <= '0;
      bpfDiv_reg  <= '0;
      bpfTick_reg <= 1'b0;
    end else begin
      accDiv_reg  <= accDiv_next;
      bpfDiv_reg  <= bpfDiv_next;
      bpfTick_reg <= bpfTick_next;
    end
  end

  assign bpfSampleEn = bpfTick_reg;

  // ---------------------------------------------------------------------------
  // Per-path energy accumulator against anti-creep accumulator
  // ---------------------------------------------------------------------------
  logic [31:0]      pathPower  [2];
  logic [31:0]      pulseThr   [2];
  logic [31:0]      noloadThr  [2];
  logic [IDX_W-1:0] accIdx     [2];
  logic [ACC_W-1:0] energyAcc  [2];
  logic             creepState [2];
  logic             pulseOut   [2];

  // Path one may run from the preset constant instead of measured power.
  assign pathPower[0] = constSel ? cal_reg[SLOT_CONST]
                                 : powerPathOne;
  assign pathPower[1] = powerPathTwo;
  assign pulseThr[0]  = cal_reg[SLOT_PULSE_P1];
  assign pulseThr[1]  = cal_reg[SLOT_PULSE_P2];
  assign noloadThr[0] = cal_reg[SLOT_NOLOAD_P1];
  assign noloadThr[1] = cal_reg[SLOT_NOLOAD_P2];
  assign accIdx[0]    = IDX_ENERGY_ACC_PATH1;
  assign accIdx[1]    = IDX_ENERGY_ACC_PATH2;

  for (genvar p = 0; p < 2; p++) begin : g_path
    logic [ACC_W-1:0] eAcc_reg, eAcc_next;
    logic [31:0]      cAcc_reg, cAcc_next;
    logic             creep_reg, creep_next;
    logic             half_reg, half_next;
    logic             pulse_reg, pulse_next;
    logic             ovfEv, creepEv;
    logic [31:0]      mag;
    logic [ACC_W-1:0] sum, thr42;
    logic [31:0]      cSum;
    logic             eOvf, cOvf;

    always_comb begin
      // Energy is counted by magnitude; direction belongs to the datapath.
      mag   = pathPower[p][31] ? 32'(-pathPower[p]) : pathPower[p];
      thr42 = {pulseThr[p], {PAD_W{1'b0}}};
      sum   = eAcc_reg + {{PAD_W{1'b0}}, mag};
      cSum  = noloadEn ? cAcc_reg + 32'h0000_0001 : cAcc_reg;
      eOvf  = (sum >= thr42);
      cOvf  = noloadEn && (cSum >= noloadThr[p]);
      eAcc_next  = eAcc_reg;
      cAcc_next  = cAcc_reg;
      creep_next = creep_reg;
      half_next  = half_reg;
      pulse_next = 1'b0;
      ovfEv      = 1'b0;
      creepEv    = 1'b0;
      if (accTick && accEn) begin
        if (eOvf) begin
          // A tie goes to the energy side: the path keeps metering.
          eAcc_next  = sum - thr42;
          cAcc_next  = '0;
          creep_next = 1'b0;
          ovfEv      = 1'b1;
          if (cfEn) begin
            half_next  = ~half_reg;
            pulse_next = half_reg;
          end
        end else if (cOvf) begin
          eAcc_next  = '0;
          cAcc_next  = '0;
          creep_next = 1'b1;
          creepEv    = ~creep_reg;
        end else begin
          eAcc_next = sum;
          cAcc_next = cSum;
        end
      end
      if (!noloadEn) begin
        cAcc_next  = '0;
        creep_next = 1'b0;
      end
      if (wrEn && regIdx == accIdx[p]) begin
        eAcc_next = {mergeSel(eAcc_reg[ACC_W-1:PAD_W], wbDatWr, wbSel),
                     {PAD_W{1'b0}}};
      end
      if (softClear) begin
        eAcc_next  = '0;
        cAcc_next  = '0;
        creep_next = 1'b0;
        half_next  = 1'b0;
        pulse_next = 1'b0;
      end
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        eAcc_reg  <= '0;
        cAcc_reg  <= '0;
        creep_reg <= 1'b0;
        half_reg  <= 1'b0;
        pulse_reg <= 1'b0;
      end else begin
        eAcc_reg  <= eAcc_next;
        cAcc_reg  <= cAcc_next;
        creep_reg <= creep_next;
        half_reg  <= half_next;
        pulse_reg <= pulse_next;
      end
    end

    assign energyAcc[p]                = eAcc_reg;
    assign creepState[p]               = creep_reg;
    assign pulseOut[p]                 = pulse_reg;
    assign irqEvents[IRQ_OVF_LSB + p]   = ovfEv;
    assign irqEvents[IRQ_CREEP_LSB + p] = creepEv;
  end

  assign calPulseOutOne = pulseOut[0];
  assign calPulseOutTwo = pulseOut[1];
  assign creepOne       = creepState[0];
  assign creepTwo       = creepState[1];

  // ---------------------------------------------------------------------------
  // Read path and acknowledge
  // ---------------------------------------------------------------------------
  always_comb begin
    ack_next    = wbCyc & wbStb & ~ack_reg;
    rdData_next = rdData_reg;
    if (wbCyc && wbStb && !ack_reg) begin
      // Unmapped addresses are acknowledged and read as zero.
      rdData_next = 32'h0000_0000;
      for (int i = 0; i < NUM_CAL; i++) begin
        if (regIdx == CAL_INDEX[i]) begin
          rdData_next = cal_reg[i];
        end
      end
      case (regIdx)
        IDX_ENERGY_ACC_PATH1: rdData_next = energyAcc[0][ACC_W-1:PAD_W];
        IDX_ENERGY_ACC_PATH2: rdData_next = energyAcc[1][ACC_W-1:PAD_W];
        IDX_METER_CONTROL:    rdData_next = ctrl_reg;
        IDX_IRQ_STATUS:       rdData_next = {28'h0, irqStat_reg};
        IDX_IRQ_MASK:         rdData_next = {28'h0, irqMask_reg};
        IDX_CREEP_STATUS: begin
          rdData_next = 32'h0000_0000;
          rdData_next[CREEP_BIT_P1] = creepState[0];
          rdData_next[CREEP_BIT_P2] = creepState[1];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h0000_0000;
    end else begin
      ack_reg    <= ack_next;
      rdData_reg <= rdData_next;
    end
  end

  assign wbAck   = ack_reg;
  assign wbDatRd = rdData_reg;

endmodule

/* verif/meter_cal_monitor.sv */
// Bus, pulse and calibration-word checks bound to the calibration block.
`timescale 1ns/1ps
module meter_cal_monitor
  import meter_cal_pkg::*;
(
  // Clock and resets
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        resetBrownOut,
  input wire logic        resetWatchdog,
  // Register bus
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic        wbAck,
  // Watched outputs
  input wire logic [31:0] gainCalPowerPath1,
  input wire logic [31:0] rmsBandpassCoefficient,
  input wire logic        bpfSampleEn,
  input wire logic        calPulseOutOne,
  input wire logic        calPulseOutTwo
);
  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ack_single_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  ack_timely_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("request not answered in one cycle");
  coef_reset_value_a: assert property (
    $rose(nrst) |-> rmsBandpassCoefficient == BPF_COEF_RESET)
    else $error("filter coefficient not at reset value");
  // A word may only move after a write or a synchronous reset.
  gain_write_only_a: assert property ($changed(gainCalPowerPath1) |->
    $past(wbAck && wbWe) || $past(resetBrownOut || resetWatchdog))
    else $error("gain word changed without a write");
  coef_write_only_a: assert property ($changed(rmsBandpassCoefficient) |->
    $past(wbAck && wbWe) || $past(resetBrownOut || resetWatchdog))
    else $error("coefficient changed without a write");
  pulse_one_gap_a: assert property (
    calPulseOutOne |=> !calPulseOutOne [*8])
    else $error("path one pulses too close");
  pulse_two_gap_a: assert property (
    calPulseOutTwo |=> !calPulseOutTwo [*8])
    else $error("path two pulses too close");
  bpf_enable_gap_a: assert property (bpfSampleEn |=> !bpfSampleEn [*8])
    else $error("filter enable too close");
endmodule

bind meter_calibration_anticreep meter_cal_monitor mon (
  .clk(clk), .nrst(nrst), .resetBrownOut(resetBrownOut),
  .resetWatchdog(resetWatchdog), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbWe(wbWe), .wbAck(wbAck), .gainCalPowerPath1(gainCalPowerPath1),
  .rmsBandpassCoefficient(rmsBandpassCoefficient),
  .bpfSampleEn(bpfSampleEn), .calPulseOutOne(calPulseOutOne),
  .calPulseOutTwo(calPulseOutTwo));

/* verif/tb.sv */
// Self-checking bench: register map, resets, metering race and interrupt.
`timescale 1ns/1ps
module tb
  import meter_cal_pkg::*;
;
  // ---------------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------------
  logic        clk = 0, nrst = 0, resetBrownOut = 0, resetWatchdog = 0;
  logic        wbCyc = 0, wbStb = 0, wbWe = 0;
  logic [15:0] wbAdr = '0;
  logic [3:0]  wbSel = '0;
  logic [31:0] wbDatWr = '0, powerPathOne = '0, powerPathTwo = '0, q;
  logic [31:0] wbDatRd, gainCalPowerPath1, currentDetectThreshold;
  logic [31:0] rmsBandpassCoefficient;
  logic [31:0] gainCalPowerPath2, gainCalVoltageRms, gainCalCurrentOneRms;
  logic [31:0] gainCalCurrentTwoRms, offsetCalPowerPath1, offsetCalPowerPath2;
  logic        wbAck, bpfSampleEn, calPulseOutOne, calPulseOutTwo;
  logic        creepOne, creepTwo, irq;
  int          errorCnt = 0, checksDone = 0;

  always #2 clk = ~clk;

  meter_calibration_anticreep #(.ACCUM_CYCLES_FAST(20),
    .ACCUM_CYCLES_SLOW(40), .BPF_CYCLES_LOW(30), .BPF_CYCLES_NOM(10)) uut (
    .clk(clk), .nrst(nrst), .resetBrownOut(resetBrownOut),
    .resetWatchdog(resetWatchdog), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr),
    .wbDatRd(wbDatRd), .wbAck(wbAck), .powerPathOne(powerPathOne),
    .powerPathTwo(powerPathTwo),
    .currentDetectThreshold(currentDetectThreshold),
    .gainCalPowerPath1(gainCalPowerPath1),
    .gainCalPowerPath2(gainCalPowerPath2),
    .gainCalVoltageRms(gainCalVoltageRms),
    .gainCalCurrentOneRms(gainCalCurrentOneRms),
    .gainCalCurrentTwoRms(gainCalCurrentTwoRms),
    .offsetCalPowerPath1(offsetCalPowerPath1),
    .offsetCalPowerPath2(offsetCalPowerPath2),
    .rmsBandpassCoefficient(rmsBandpassCoefficient),
    .bpfSampleEn(bpfSampleEn), .calPulseOutOne(calPulseOutOne),
    .calPulseOutTwo(calPulseOutTwo), .creepOne(creepOne),
    .creepTwo(creepTwo), .irq(irq));

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic report_and_stop;
    if (errorCnt == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp, input string nm);
    checksDone++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Called right after a rising edge; holds the request until ack is seen.
  task automatic wb(input logic we, input logic [13:0] ix,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wbCyc <= 1;
    wbStb <= 1;
    wbWe <= we;
    wbAdr <= {ix, 2'b00};
    wbSel <= s;
    wbDatWr <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 100);
    q = wbDatRd;
    wbCyc <= 0;
    wbStb <= 0;
    @(posedge clk);
    if (n >= 100) errorCnt++;
  endtask

  task automatic wr(input logic [13:0] ix, input logic [31:0] d);
    wb(1, ix, d, 4'hF);
  endtask

  task automatic rdc(input logic [13:0] ix, input logic [31:0] e,
                     input string nm);
    wb(0, ix, 32'h0, 4'hF);
    chk(q, e, nm);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return calPulseOutOne;
      1: return calPulseOutTwo;
      2: return bpfSampleEn;
      default: return creepTwo;
    endcase
  endfunction

  // Waits for one event, then counts cycles to the next one.
  task automatic gap(input int s, input int e, input string nm);
    int n;
    n = 0;
    while (pick(s) !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(s) !== 1'b1 && n < 2000);
    chk(n, e, nm);
  endtask

  task automatic waitv(input logic v);
    int n;
    n = 0;
    while (creepTwo !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(creepTwo, v, "creepTwo");
  endtask

  // ---------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    for (int i = 0; i < NUM_CAL; i++)
      rdc(CAL_INDEX[i], CAL_RESET[i], "default");
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < NUM_CAL; i++) wr(CAL_INDEX[i], 32'hC3A5_0000 + i);
      for (int i = 0; i < NUM_CAL; i++)
        rdc(CAL_INDEX[i], 32'hC3A5_0000 + i, "readback");
      chk(gainCalPowerPath1, 32'hC3A5_0001, "gainPort");
      chk(gainCalPowerPath2, 32'hC3A5_0002, "gain2Port");
      chk(gainCalVoltageRms, 32'hC3A5_0003, "gainUPort");
      chk(gainCalCurrentOneRms, 32'hC3A5_0004, "gainI1Port");
      chk(gainCalCurrentTwoRms, 32'hC3A5_0005, "gainI2Port");
      chk(offsetCalPowerPath1, 32'hC3A5_0006, "ofs1Port");
      chk(offsetCalPowerPath2, 32'hC3A5_0007, "ofs2Port");
      chk(currentDetectThreshold, 32'hC3A5_0000, "idetPort");
      if (r == 0) resetBrownOut <= 1;
      else resetWatchdog <= 1;
      @(posedge clk);
      resetBrownOut <= 0;
      resetWatchdog <= 0;
      @(posedge clk);
      for (int i = 0; i < NUM_CAL; i++)
        rdc(CAL_INDEX[i], CAL_RESET[i], "afterReset");
    end
    chk(rmsBandpassCoefficient, BPF_COEF_RESET, "coefPort");
    wb(1, IDX_GAIN_CAL_VOLTAGE_RMS, 32'hFFFF_FFFF, 4'h2);
    rdc(IDX_GAIN_CAL_VOLTAGE_RMS, 32'h0000_FF00, "byteSel");
    wr(14'h1003, 32'h1234_5678);
    rdc(14'h1003, 32'h0, "unmapped");
    wr(IDX_ENERGY_ACC_PATH1, 32'h1234_5678);
    rdc(IDX_ENERGY_ACC_PATH1, 32'h1234_5678, "accUpper");
    wr(IDX_ENERGY_ACC_PATH1, 32'h0);
    wr(IDX_METER_CONTROL, 32'h3);
    gap(0, 40, "pulseOneThr0");
    gap(1, 40, "pulseTwoThr0");
    wr(IDX_PULSE_THRESHOLD_PATH1, 32'h1);
    powerPathOne <= 32'hFFFF_FF00;
    gap(0, 160, "pulseOnePower");
    wr(IDX_CONSTANT_POWER_VALUE, 32'h200);
    wr(IDX_METER_CONTROL, 32'hB);
    gap(0, 80, "pulseConst");
    wr(IDX_METER_CONTROL, 32'h33);
    gap(1, 80, "pulseSlowRate");
    gap(2, 10, "bpfNominal");
    wr(IDX_METER_CONTROL, 32'h20);
    wr(IDX_RMS_BANDPASS_COEFFICIENT, 32'h911D_3C9C);
    chk(rmsBandpassCoefficient, 32'h911D_3C9C, "coefLow");
    gap(2, 30, "bpfLowRate");
    wr(IDX_NOLOAD_THRESHOLD_PATH2, 32'h3);
    wr(IDX_PULSE_THRESHOLD_PATH2, 32'h1);
    wr(IDX_IRQ_MASK, 32'h8);
    wr(IDX_METER_CONTROL, 32'h5);
    wr(IDX_RMS_BANDPASS_COEFFICIENT, BPF_COEF_RESET);
    chk(rmsBandpassCoefficient, BPF_COEF_RESET, "coefBack");
    waitv(1);
    wb(0, IDX_CREEP_STATUS, 32'h0, 4'hF);
    chk(q & 32'h40, 32'h40, "creepBit");
    chk(irq, 1, "irqSet");
    wr(IDX_IRQ_STATUS, 32'h8);
    chk(irq, 0, "irqCleared");
    powerPathTwo <= 32'h800;
    waitv(0);
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    report_and_stop;
  end
endmodule
